// File: rtl/tcs_defines.svh
// Constants of the thermocouple channel scanner.
// Behaviour
// - Multiplexed mode hands one channel result to the host per scan.
// - After the last enabled channel, multiplexing wraps to channel zero.
// - Disabled channels are skipped; rotation covers selected ones only.
// - Pointer mode hands all enabled channel results within one host scan.
// - Each channel converts on its own timing into a 16-bit result.
// - Results reach the host only in step with host scans.
// - Latency: 160 ms minimum, channels times 160 ms plus a scan maximum.
// - Two select bits give the enabled count: 00=1, 01=2, 10=3, 11=4.
// - A negative temperature sets the most significant bit of the word.
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

// Clock rate and per-channel conversion slot.
`define TCS_CLK_HZ        40000000
`define TCS_CONV_MS       160
`define TCS_CONV_CYC      ((`TCS_CLK_HZ / 1000) * `TCS_CONV_MS)

// Word layout: sign in the top bit of the 16-bit result.
`define TCS_SIGN_BIT      15
`define TCS_DATA_W        16
`define TCS_CH_W          2
`define TCS_NUM_CH        4

// Pointer reset value and FIFO depth.
`define TCS_PTR_RST       2'h0
`define TCS_FIFO_DEPTH    16

`endif

// File: rtl/tcs_pkg.sv
// Types of the thermocouple channel scanner.
package tcs_pkg;
   typedef enum logic [1:0] {
      TCS_IDLE  = 2'b00,
      TCS_SEND  = 2'b01,
      TCS_DRAIN = 2'b10
   } tcs_state_t;
endpackage

// File: rtl/tcs_fifo.sv
// Synchronous FIFO with registered read data, valid and ready on both sides.
`timescale 1ns/1ps
module tcs_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Write side.
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   // Read side.
   output logic      [WIDTH-1:0] rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   // Fill level.
   output logic [$clog2(DEPTH):0] level_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic [WIDTH-1:0] dout_q, dout_d;
   logic             dv_q, dv_d;
   logic             push, pop, load;

   // The output register counts as one slot beyond the array.
   always_comb begin
      push     = wr_valid_in && (cnt_q != DEPTH[AW:0]);
      load     = (cnt_q != '0) && (!dv_q || rd_ready_in);
      pop      = dv_q && rd_ready_in;
      wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_d = load ? rd_ptr_q + 1'b1 : rd_ptr_q;
      cnt_d    = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      dout_d   = load ? mem_q[rd_ptr_q] : dout_q;
      dv_d     = load ? 1'b1 : (pop ? 1'b0 : dv_q);
   end

   // Pointers, counts and the output register.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
         dout_q   <= '0;
         dv_q     <= 1'b0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         cnt_q    <= cnt_d;
         dout_q   <= dout_d;
         dv_q     <= dv_d;
      end
   end

   // Storage array has no reset so it can map to memory.
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q] <= wr_data_in;
      end
   end

   assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
   assign rd_data_out  = dout_q;
   assign rd_valid_out = dv_q;
   assign level_out    = cnt_q;
endmodule

// File: rtl/tcs_scanner.sv
// Top of the thermocouple channel scanner: conversion timing and hand-over.
`timescale 1ns/1ps
`include "tcs_defines.svh"
module tcs_scanner #(
   parameter int CONV_CYC   = `TCS_CONV_CYC,
   parameter int FIFO_DEPTH = `TCS_FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic        CLK_IN,
   input  wire logic        RST_IN,
   // Channel count selection and format.
   input  wire logic        COUNT_SELECT_LOW_IN,
   input  wire logic        COUNT_SELECT_HIGH_IN,
   input  wire logic        TWOS_COMP_IN,
   // Analog front end, one conversion per channel slot.
   input  wire logic [15:0] ADC_MAG_IN,
   input  wire logic        ADC_NEG_IN,
   output logic [1:0]       ADC_CH_OUT,
   output logic             ADC_SAMPLE_OUT,
   // Host scan interface.
   input  wire logic        SCAN_IN,
   input  wire logic        POINTER_MODE_IN,
   input  wire logic        HOST_READY_IN,
   output logic [15:0]      HOST_DATA_OUT,
   output logic [1:0]       HOST_CH_OUT,
   output logic             HOST_VALID_OUT,
   output logic             SCAN_DONE_OUT,
   output logic             CONV_STALL_OUT
);
   localparam int DW = `TCS_DATA_W;
   localparam int CW = `TCS_CH_W;
   localparam int TW = $clog2(CONV_CYC + 1);

   // Channel count from the two select bits.
   logic [CW-1:0] last_ch;
   always_comb begin
      last_ch = {COUNT_SELECT_HIGH_IN, COUNT_SELECT_LOW_IN};
   end

   // Conversion side: one slot of CONV_CYC per enabled channel, free running.
   logic [TW-1:0]  tmr_q, tmr_d;
   logic [CW-1:0]  cch_q, cch_d;
   logic [DW-1:0]  res_q [`TCS_NUM_CH];
   logic [DW-1:0]  res_d [`TCS_NUM_CH];
   logic           samp_q, samp_d;
   logic [DW-1:0]  conv_word;

   // Sign-magnitude keeps 15-bit magnitude with the sign on top; both
   // formats therefore show a negative reading by the top bit.
   always_comb begin
      if (!ADC_NEG_IN) begin
         conv_word = {1'b0, ADC_MAG_IN[DW-2:0]};
      end else if (TWOS_COMP_IN) begin
         conv_word = (~{1'b0, ADC_MAG_IN[DW-2:0]}) + 16'h0001;
      end else begin
         conv_word = {1'b1, ADC_MAG_IN[DW-2:0]};
      end
      if (ADC_NEG_IN && (ADC_MAG_IN[DW-2:0] == 15'h0000)) begin
         conv_word = 16'h8000;
      end
   end

   // Conversion runs with no regard to host scans.
   always_comb begin
      tmr_d  = tmr_q;
      cch_d  = cch_q;
      res_d  = res_q;
      samp_d = 1'b0;
      if (tmr_q == TW'(CONV_CYC - 1)) begin
         tmr_d  = '0;
         samp_d = 1'b1;
         res_d[cch_q] = conv_word;
         // The slot per channel bounds latency by count times the slot.
         cch_d = (cch_q >= last_ch) ? `TCS_PTR_RST : cch_q + 1'b1;
      end else begin
         tmr_d = tmr_q + 1'b1;
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         tmr_q  <= '0;
         cch_q  <= `TCS_PTR_RST;
         samp_q <= 1'b0;
         for (int i = 0; i < `TCS_NUM_CH; i++) begin
            res_q[i] <= '0;
         end
      end else begin
         tmr_q  <= tmr_d;
         cch_q  <= cch_d;
         samp_q <= samp_d;
         res_q  <= res_d;
      end
   end

   // Hand-over side: words enter the FIFO only on a host scan.
   tcs_pkg::tcs_state_t st_q, st_d;
   logic [CW-1:0]  mux_q, mux_d;
   logic [CW-1:0]  idx_q, idx_d;
   logic [CW-1:0]  stop_q, stop_d;
   logic           push;
   logic [DW+CW-1:0] push_word;
   logic           fifo_ready;
   logic [DW+CW-1:0] pop_word;
   logic           pop_valid;
   logic           done_q, done_d;
   logic           stall_q, stall_d;
   logic [$clog2(FIFO_DEPTH):0] level;

   always_comb begin
      st_d      = st_q;
      mux_d     = mux_q;
      idx_d     = idx_q;
      stop_d    = stop_q;
      done_d    = 1'b0;
      stall_d   = 1'b0;
      push      = 1'b0;
      push_word = {idx_q, res_q[idx_q]};
      unique case (st_q)
         tcs_pkg::TCS_IDLE: begin
            if (SCAN_IN) begin
               if (POINTER_MODE_IN) begin
                  idx_d  = '0;
                  stop_d = last_ch;
               end else begin
                  // Pointer may sit past a channel just disabled.
                  idx_d  = (mux_q > last_ch) ? `TCS_PTR_RST : mux_q;
                  stop_d = (mux_q > last_ch) ? `TCS_PTR_RST : mux_q;
               end
               st_d = tcs_pkg::TCS_SEND;
            end
         end
         tcs_pkg::TCS_SEND: begin
            stall_d = !fifo_ready;
            if (fifo_ready) begin
               push = 1'b1;
               if (idx_q == stop_q) begin
                  if (!POINTER_MODE_IN) begin
                     mux_d = (idx_q >= last_ch) ? `TCS_PTR_RST
                                                : idx_q + 1'b1;
                  end
                  st_d = tcs_pkg::TCS_DRAIN;
               end else begin
                  idx_d = idx_q + 1'b1;
               end
            end
         end
         tcs_pkg::TCS_DRAIN: begin
            // Scan completes once the host has taken every word.
            if (level == '0 && !pop_valid) begin
               done_d = 1'b1;
               st_d   = tcs_pkg::TCS_IDLE;
            end
         end
         default: begin
            st_d = tcs_pkg::TCS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         st_q    <= tcs_pkg::TCS_IDLE;
         mux_q   <= `TCS_PTR_RST;
         idx_q   <= `TCS_PTR_RST;
         stop_q  <= `TCS_PTR_RST;
         done_q  <= 1'b0;
         stall_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         mux_q   <= mux_d;
         idx_q   <= idx_d;
         stop_q  <= stop_d;
         done_q  <= done_d;
         stall_q <= stall_d;
      end
   end

   // Buffer between scan sequencer and host; host can stall it.
   tcs_fifo #(
      .WIDTH (DW + CW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (CLK_IN),
      .rst_in       (RST_IN),
      .wr_data_in   (push_word),
      .wr_valid_in  (push),
      .wr_ready_out (fifo_ready),
      .rd_data_out  (pop_word),
      .rd_valid_out (pop_valid),
      .rd_ready_in  (HOST_READY_IN),
      .level_out    (level)
   );

   // Outputs straight from flip-flops.
   assign ADC_CH_OUT     = cch_q;
   assign ADC_SAMPLE_OUT = samp_q;
   assign HOST_DATA_OUT  = pop_word[DW-1:0];
   assign HOST_CH_OUT    = pop_word[DW+CW-1:DW];
   assign HOST_VALID_OUT = pop_valid;
   assign SCAN_DONE_OUT  = done_q;
   assign CONV_STALL_OUT = stall_q;
endmodule

// File: bench/tcs_scanner_checker.sv
// Checker of scanner hand-over and conversion timing.
`timescale 1ns/1ps
module tcs_checker #(parameter int CONV_CYC = 20) (
   input wire logic        CLK_IN, RST_IN, SCAN_IN, HOST_READY_IN,
   input wire logic        POINTER_MODE_IN, HOST_VALID_OUT, SCAN_DONE_OUT,
   input wire logic        ADC_SAMPLE_OUT, CONV_STALL_OUT,
   input wire logic        COUNT_SELECT_LOW_IN, COUNT_SELECT_HIGH_IN,
   input wire logic [1:0]  ADC_CH_OUT, HOST_CH_OUT,
   input wire logic [15:0] HOST_DATA_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   logic busy_q;
   logic seen_q;
   int   gap_q;
   // Open scan and result spacing; spacing is checked again only from the second sample after a stall.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         busy_q <= 1'b0;
         seen_q <= 1'b0;
         gap_q  <= 0;
      end else begin
         busy_q <= SCAN_DONE_OUT ? 1'b0 : (busy_q | SCAN_IN);
         gap_q  <= ADC_SAMPLE_OUT ? 0 : gap_q + 1;
         seen_q <= CONV_STALL_OUT ? 1'b0 : (seen_q | ADC_SAMPLE_OUT);
      end
   end
   valid_hold_a: assert property (HOST_VALID_OUT && !HOST_READY_IN
      |=> HOST_VALID_OUT && $stable(HOST_DATA_OUT) && $stable(HOST_CH_OUT))
      else $error("word changed before taken");
   mux_one_a: assert property (HOST_VALID_OUT && HOST_READY_IN &&
      !POINTER_MODE_IN |=> !HOST_VALID_OUT ##1 SCAN_DONE_OUT)
      else $error("multiplexed scan did not end after one word");
   scan_ans_a: assert property (SCAN_IN && !busy_q
      |-> ##3 HOST_VALID_OUT) else $error("scan not answered");
   done_pulse_a: assert property (SCAN_DONE_OUT |=> !SCAN_DONE_OUT)
      else $error("done longer than one cycle");
   sample_pulse_a: assert property (ADC_SAMPLE_OUT |=> !ADC_SAMPLE_OUT)
      else $error("sample longer than one cycle");
   slot_len_a: assert property (ADC_SAMPLE_OUT && seen_q
      |-> gap_q == CONV_CYC - 1) else $error("slot length wrong");
   adc_step_a: assert property ($changed(ADC_CH_OUT) |->
      ADC_CH_OUT == 2'h0 || ADC_CH_OUT == $past(ADC_CH_OUT) + 2'h1)
      else $error("conversion channel out of order");
   ch_range_a: assert property (HOST_VALID_OUT |-> HOST_CH_OUT <=
      {COUNT_SELECT_HIGH_IN, COUNT_SELECT_LOW_IN})
      else $error("word from a disabled channel");
   mux_c: cover property (HOST_VALID_OUT && HOST_READY_IN &&
      !POINTER_MODE_IN);
   ptr_c: cover property (HOST_VALID_OUT && HOST_READY_IN &&
      POINTER_MODE_IN);
   stall_c: cover property (HOST_VALID_OUT && !HOST_READY_IN);
endmodule
bind tcs_scanner tcs_checker #(.CONV_CYC(CONV_CYC)) chk (
   .CLK_IN(CLK_IN), .RST_IN(RST_IN), .SCAN_IN(SCAN_IN),
   .HOST_READY_IN(HOST_READY_IN), .POINTER_MODE_IN(POINTER_MODE_IN),
   .HOST_VALID_OUT(HOST_VALID_OUT), .SCAN_DONE_OUT(SCAN_DONE_OUT),
   .ADC_SAMPLE_OUT(ADC_SAMPLE_OUT), .CONV_STALL_OUT(CONV_STALL_OUT),
   .COUNT_SELECT_LOW_IN(COUNT_SELECT_LOW_IN),
   .COUNT_SELECT_HIGH_IN(COUNT_SELECT_HIGH_IN), .ADC_CH_OUT(ADC_CH_OUT),
   .HOST_CH_OUT(HOST_CH_OUT), .HOST_DATA_OUT(HOST_DATA_OUT)
);

// File: bench/tcs_host_model.sv
// Behavioural host that collects scanner words, stalling when asked.
`timescale 1ns/1ps
module tcs_host_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        slow_in,
   input  wire logic        valid_in,
   input  wire logic [15:0] data_in,
   input  wire logic [1:0]  ch_in,
   output logic             ready_out
);
   logic [17:0] word_q [0:31];
   int          n_q;
   // A slow host toggles ready, so a word must stand until it is taken.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ready_out <= 1'b0;
         n_q       <= 0;
      end else begin
         ready_out <= slow_in ? ~ready_out : 1'b1;
         if (valid_in && ready_out) begin
            word_q[n_q[4:0]] <= {ch_in, data_in};
            n_q              <= n_q + 1;
         end
      end
   end
endmodule

// File: bench/tcs_scanner_tb_top.sv
// Self-checking bench of the channel scanner with a host model.
`timescale 1ns/1ps
module tcs_scanner_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        lo = 1'b1;
   logic        hi = 1'b1;
   logic        tc = 1'b0;
   logic        pm = 1'b0;
   logic        scan = 1'b0;
   logic        slow = 1'b0;
   logic [15:0] mag = 16'h0000;
   logic        neg = 1'b0;
   logic [1:0]  adc_ch, h_ch;
   logic [15:0] h_data;
   logic        ready, valid, done;
   int          n_fail = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          ptr = 0;
   int          last = 3;
   always #12.5 clk = ~clk;
   tcs_scanner #(.CONV_CYC(20)) uut (
      .CLK_IN(clk), .RST_IN(rst), .COUNT_SELECT_LOW_IN(lo),
      .COUNT_SELECT_HIGH_IN(hi), .TWOS_COMP_IN(tc), .ADC_MAG_IN(mag),
      .ADC_NEG_IN(neg), .ADC_CH_OUT(adc_ch), .ADC_SAMPLE_OUT(),
      .SCAN_IN(scan), .POINTER_MODE_IN(pm), .HOST_READY_IN(ready),
      .HOST_DATA_OUT(h_data), .HOST_CH_OUT(h_ch), .HOST_VALID_OUT(valid),
      .SCAN_DONE_OUT(done), .CONV_STALL_OUT()
   );
   tcs_host_model host (
      .clk_in(clk), .rst_in(rst), .slow_in(slow), .valid_in(valid),
      .data_in(h_data), .ch_in(h_ch), .ready_out(ready)
   );
   // Each channel reads its own value; odd channels read negative.
   always @(posedge clk) begin
      mag <= 16'h0100 + {14'h0000, adc_ch};
      neg <= adc_ch[0];
   end
   function automatic logic [17:0] exp_word(input int c);
      logic [15:0] m;
      m = 16'h0100 + c[15:0];
      if (!c[0]) return {c[1:0], m};
      return {c[1:0], tc ? 16'h0000 - m : {1'b1, m[14:0]}};
   endfunction
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Settings change only while idle, then every slot converts again.
   task automatic cfg(input logic [1:0] s, input logic t, p, w);
      @(posedge clk);
      {hi, lo} <= s;
      tc <= t;
      pm <= p;
      slow <= w;
      last = s;
      if (ptr > last) ptr = 0;
      repeat (120) @(posedge clk);
   endtask
   task automatic do_scan(input int n);
      int base;
      int k;
      base = host.n_q;
      @(posedge clk);
      scan <= 1'b1;
      @(posedge clk);
      scan <= 1'b0;
      for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk);
      check(18'(host.n_q - base), 18'(n));
      for (k = 0; k < n; k++) begin
         check(host.word_q[base + k], exp_word(pm ? k : ptr));
         if (!pm) ptr = (ptr == last) ? 0 : ptr + 1;
      end
   endtask
   task automatic t_mux4;
      cfg(2'b11, 1'b0, 1'b0, 1'b0);
      repeat (5) do_scan(1);
   endtask
   task automatic t_mux2;
      cfg(2'b01, 1'b0, 1'b0, 1'b1);
      repeat (3) do_scan(1);
   endtask
   task automatic t_ptr;
      cfg(2'b10, 1'b1, 1'b1, 1'b1);
      do_scan(3);
      cfg(2'b11, 1'b1, 1'b1, 1'b0);
      do_scan(4);
   endtask
   task automatic t_one;
      cfg(2'b00, 1'b1, 1'b0, 1'b0);
      repeat (2) do_scan(1);
   endtask
   task automatic final_report;
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Whole run needs under 1500 cycles; a hang stops here.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_mux4();
      t_mux2();
      t_ptr();
      t_one();
      final_report();
   end
endmodule
